// ===== design/serial_break_wake_and_sync_host.sv
/*
  Serial port core: asynchronous transmit with break characters,
  asynchronous receive with wake-on-activity, and synchronous host
  transmit and receive with generated shift clock.
  Assumes pins arrive unsynchronised and a tristate resolver outside.
*/
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RQ1] wake enabled: reception held idle, falling wakes
// [RQ2] nonzero char: first low interval wakes
// [RQ3] far sender starts with long zero character
// [RQ4] wake sets receive flag; rising edge clears wake
// [RQ5] receive data read clears receive flag
// [RQ6] software checks receiver idle before wake
// [RQ7] break: start, twelve zeros, stop
// [RQ8] data write with send-break sends zeros
// [RQ9] send-break self clears after break stop
// [RQ10] shift empty status covers break too
// [RQ11] host writes dummy then sync byte
// [RQ12] transmit empty flag when holding drains
// [RQ13] break received: flag, framing error, zero
// [RQ14] wake: edges flag, then next byte flags
// [RQ15] synchronous: no start/stop, half duplex
// [RQ16] host needs sync, source, port enables
// [RQ17] host drives clock pin automatically
// [RQ18] one clock per data bit only
// [RQ19] clock polarity picks idle level, edges
// [RQ20] holding waits while shifter busy
// [RQ21] data changes on leading edge, pin driven
// [RQ22] data polarity inverts both directions
module serial_break_wake_and_sync_host (
  // clock, reset, enable
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 ce,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [7:0]           reg_rdata,
  // receive_or_data_pin
  input  wire logic                 receive_or_data_pin_in,
  output var  serial_pkg::pin_drive_t receive_or_data_pin,
  // transmit_or_clock_pin
  input  wire logic                 transmit_or_clock_pin_in,
  output var  serial_pkg::pin_drive_t transmit_or_clock_pin,
  // flags
  output var  logic                 receive_interrupt_flag,
  output var  logic                 transmit_buffer_empty_flag
);

  // ==========================================================
  // declarations
  logic        clock_source_select, transmit_enable, sync_mode;
  logic        send_break_control, port_enable, single_receive_enable;
  logic        continuous_receive_enable, data_polarity_select;
  logic        clock_polarity_select, wake_on_activity_enable;
  logic [15:0] baud_div, baud_cnt, rx_cnt;
  logic        rx_meta, rx_sync, rx_prev, ck_meta, ck_sync;
  logic        rx_lvl, rx_fall, rx_rise;
  logic        shift_register_empty, receiver_idle_status;
  logic        framing_error_flag;
  logic [7:0]  hold_data, tx_shift, s_shift, rx_shift, rx_data;
  logic        hold_brk, tx_brk, tx_line, sclk, sdat, s_phase, s_rx;
  logic [3:0]  tx_bit;
  logic [2:0]  s_bit, rx_bit;
  serial_pkg::tx_state_t   tx_state;
  serial_pkg::rx_state_t   rx_state;
  serial_pkg::sync_state_t s_state;
  logic        tick, sync_host, rx_mode, load, brk_pending, brk_done;
  logic        s_done, a_done, rx_on, restart;

  // ==========================================================
  // pin synchronisers; first stage read only by second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      rx_prev <= 1'b1;
    end else if (ce) begin
      rx_meta <= receive_or_data_pin_in;
      rx_sync <= rx_meta;
      ck_meta <= transmit_or_clock_pin_in;
      ck_sync <= ck_meta;
      rx_prev <= rx_lvl;
    end
  end

  // line level after polarity, and its edges
  assign rx_lvl  = rx_sync ^ data_polarity_select; // RQ22
  assign rx_fall = ce && rx_prev && !rx_lvl;
  assign rx_rise = ce && !rx_prev && rx_lvl;

  // ==========================================================
  // mode decode and transfer triggers
  assign sync_host = port_enable && sync_mode && clock_source_select; // RQ16
  assign rx_mode   = single_receive_enable || continuous_receive_enable;
  assign tick      = ce && (baud_cnt == 16'h0000);
  assign brk_pending = (tx_state != serial_pkg::TX_IDLE && tx_brk) ||
                       (!transmit_buffer_empty_flag && hold_brk);
  // holding moves only when the async transmit and sync shifters are free
  assign load = ce && !transmit_buffer_empty_flag && transmit_enable && port_enable &&
                tx_state == serial_pkg::TX_IDLE && s_state == serial_pkg::S_IDLE &&
                (sync_mode ? (sync_host && !rx_mode) : 1'b1); // RQ20
  assign restart  = load || (ce && s_state == serial_pkg::S_IDLE && sync_host && rx_mode);
  assign brk_done = tick && tx_state == serial_pkg::TX_STOP && tx_brk;
  assign s_done   = tick && s_state == serial_pkg::S_RUN && s_phase && s_bit == 3'h7;
  assign rx_on    = port_enable && !sync_mode && continuous_receive_enable &&
                    !wake_on_activity_enable; // RQ1
  assign a_done   = ce && rx_state == serial_pkg::RX_STOP && rx_cnt == 16'h0000;

  // ==========================================================
  // baud generator; restarted so the first bit is whole
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      baud_cnt <= serial_pkg::BAUD_DIV_RESET;
    end else if (ce) begin
      if (restart || baud_cnt == 16'h0000) begin
        baud_cnt <= baud_div;
      end else begin
        baud_cnt <= baud_cnt - 16'h0001;
      end
    end
  end

  // ==========================================================
  // control registers; software write lands after hardware clears
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clock_source_select       <= 1'b0;
      transmit_enable           <= 1'b0;
      sync_mode                 <= 1'b0;
      send_break_control        <= 1'b0;
      port_enable               <= 1'b0;
      single_receive_enable     <= 1'b0;
      continuous_receive_enable <= 1'b0;
      data_polarity_select      <= 1'b0; // RQ22
      clock_polarity_select     <= 1'b0;
      wake_on_activity_enable   <= 1'b0;
      baud_div                  <= serial_pkg::BAUD_DIV_RESET;
    end else if (ce) begin
      if (brk_done) begin
        send_break_control <= 1'b0; // RQ9
      end
      if (s_done && s_rx) begin
        single_receive_enable <= 1'b0;
      end
      if (wake_on_activity_enable && rx_rise) begin
        wake_on_activity_enable <= 1'b0; // RQ4
      end
      if (reg_wr) begin
        case (reg_addr)
          serial_pkg::REG_TX_CTL: begin
            clock_source_select <= reg_wdata[serial_pkg::TX_CLK_SRC_BIT];
            transmit_enable     <= reg_wdata[serial_pkg::TX_EN_BIT];
            sync_mode           <= reg_wdata[serial_pkg::TX_SYNC_BIT];
            send_break_control  <= reg_wdata[serial_pkg::TX_BREAK_BIT];
          end
          serial_pkg::REG_RX_CTL: begin
            port_enable               <= reg_wdata[serial_pkg::RX_PORT_EN_BIT];
            single_receive_enable     <= reg_wdata[serial_pkg::RX_SINGLE_BIT];
            continuous_receive_enable <= reg_wdata[serial_pkg::RX_CONT_BIT];
          end
          serial_pkg::REG_RATE_CTL: begin
            data_polarity_select    <= reg_wdata[serial_pkg::RT_DPOL_BIT];
            clock_polarity_select   <= reg_wdata[serial_pkg::RT_CPOL_BIT];
            wake_on_activity_enable <= reg_wdata[serial_pkg::RT_WAKE_BIT];
          end
          serial_pkg::REG_BAUD_LO: baud_div[7:0] <= reg_wdata;
          serial_pkg::REG_BAUD_HI: baud_div[15:8] <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // holding register; a write while full is dropped unless a load happens that cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      transmit_buffer_empty_flag <= 1'b1;
      hold_data                  <= 8'h00;
      hold_brk                   <= 1'b0;
    end else if (ce) begin
      if (load) begin
        transmit_buffer_empty_flag <= 1'b1; // RQ12
      end
      if (reg_wr && reg_addr == serial_pkg::REG_TX_DATA &&
          (transmit_buffer_empty_flag || load)) begin
        hold_data                  <= reg_wdata;
        // only the first write after send-break becomes the break
        hold_brk                   <= send_break_control && transmit_enable &&
                                      !brk_pending; // RQ8
        transmit_buffer_empty_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // asynchronous transmitter with break characters
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_state <= serial_pkg::TX_IDLE;
      tx_shift <= 8'h00;
      tx_brk   <= 1'b0;
      tx_bit   <= 4'h0;
      tx_line  <= 1'b1;
    end else if (ce) begin
      case (tx_state)
        serial_pkg::TX_IDLE: begin
          tx_line <= 1'b1;
          if (load && !sync_mode) begin
            tx_shift <= hold_brk ? 8'h00 : hold_data; // RQ8
            tx_brk   <= hold_brk;
            tx_line  <= 1'b0;
            tx_state <= serial_pkg::TX_START;
          end
        end
        serial_pkg::TX_START: if (tick) begin
          tx_bit   <= 4'h0;
          tx_line  <= tx_shift[0] && !tx_brk;
          tx_state <= serial_pkg::TX_DATA;
        end
        serial_pkg::TX_DATA: if (tick) begin
          // break runs twelve zero bits instead of eight
          if (tx_bit == (tx_brk ? serial_pkg::BREAK_LAST : serial_pkg::DATA_LAST)) begin // RQ7
            tx_line  <= 1'b1;
            tx_state <= serial_pkg::TX_STOP;
          end else begin
            tx_bit   <= tx_bit + 4'h1;
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_line  <= tx_shift[1] && !tx_brk;
          end
        end
        serial_pkg::TX_STOP: if (tick) begin
          tx_state <= serial_pkg::TX_IDLE;
        end
        default: tx_state <= serial_pkg::TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // synchronous host engine: two ticks per bit, no framing bits
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_state <= serial_pkg::S_IDLE;
      s_phase <= 1'b0;
      s_bit   <= 3'h0;
      s_shift <= 8'h00;
      s_rx    <= 1'b0;
      sclk    <= 1'b0;
      sdat    <= 1'b0;
    end else if (ce) begin
      case (s_state)
        serial_pkg::S_IDLE: begin
          sclk    <= clock_polarity_select; // RQ19
          s_phase <= 1'b0;
          s_bit   <= 3'h0;
          if (load && sync_mode) begin
            s_shift <= hold_data; // RQ15
            s_rx    <= 1'b0;
            s_state <= serial_pkg::S_RUN;
          end else if (sync_host && rx_mode) begin
            s_rx    <= 1'b1;
            s_state <= serial_pkg::S_RUN;
          end
        end
        serial_pkg::S_RUN: begin
          // dropping receive mid character stops clock, discards bits
          if (!sync_host || (s_rx && !rx_mode)) begin
            sclk    <= clock_polarity_select;
            s_state <= serial_pkg::S_IDLE;
          end else if (tick && !s_phase) begin
            sclk    <= !clock_polarity_select; // RQ18
            s_phase <= 1'b1;
            if (!s_rx) begin
              sdat <= s_shift[0]; // RQ21
            end
          end else if (tick) begin
            sclk    <= clock_polarity_select; // RQ19
            s_phase <= 1'b0;
            s_shift <= s_rx ? {rx_lvl, s_shift[7:1]} : {1'b0, s_shift[7:1]};
            s_bit   <= s_bit + 3'h1;
            if (s_bit == 3'h7) begin
              s_state <= (s_rx && continuous_receive_enable) ? serial_pkg::S_RUN
                                                             : serial_pkg::S_IDLE;
            end
          end
        end
        default: s_state <= serial_pkg::S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // asynchronous receiver, sampling mid bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_state <= serial_pkg::RX_IDLE;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
    end else if (ce) begin
      if (!rx_on) begin
        rx_state <= serial_pkg::RX_IDLE; // RQ1
      end else if (rx_state == serial_pkg::RX_IDLE) begin
        if (rx_fall) begin
          rx_cnt   <= {1'b0, baud_div[15:1]};
          rx_state <= serial_pkg::RX_START;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= baud_div;
        case (rx_state)
          serial_pkg::RX_START: begin
            rx_bit   <= 3'h0;
            rx_state <= rx_lvl ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
          end
          serial_pkg::RX_DATA: begin
            rx_shift <= {rx_lvl, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= serial_pkg::RX_STOP;
            end
          end
          default: rx_state <= serial_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // receive results; a set in the read cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_data                <= 8'h00;
      framing_error_flag     <= 1'b0;
      receive_interrupt_flag <= 1'b0;
    end else if (ce) begin
      if (reg_rd && reg_addr == serial_pkg::REG_RX_DATA) begin
        receive_interrupt_flag <= 1'b0; // RQ5
      end
      if (a_done) begin
        rx_data                <= rx_shift;
        framing_error_flag     <= !rx_lvl; // RQ13
        receive_interrupt_flag <= 1'b1; // RQ14
      end
      if (s_done && s_rx) begin
        rx_data                <= {rx_lvl, s_shift[7:1]};
        framing_error_flag     <= 1'b0;
        receive_interrupt_flag <= 1'b1;
      end
      if (wake_on_activity_enable && rx_fall) begin
        receive_interrupt_flag <= 1'b1; // RQ2
      end
    end
  end

  // ==========================================================
  // status, one cycle behind the engines
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_register_empty <= 1'b1;
      receiver_idle_status <= 1'b1;
    end else if (ce) begin
      shift_register_empty <= tx_state == serial_pkg::TX_IDLE &&
                              !(s_state == serial_pkg::S_RUN && !s_rx); // RQ10
      receiver_idle_status <= rx_state == serial_pkg::RX_IDLE &&
                              !(s_state == serial_pkg::S_RUN && s_rx);
    end
  end

  // ==========================================================
  // pin drivers; enable is active low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      receive_or_data_pin   <= '{level: 1'b1, oe_n: 1'b1};
      transmit_or_clock_pin <= '{level: 1'b1, oe_n: 1'b1};
    end else if (ce) begin
      receive_or_data_pin.level <= sdat ^ data_polarity_select; // RQ22
      receive_or_data_pin.oe_n  <= !(sync_host && !rx_mode); // RQ21
      transmit_or_clock_pin.level <= sync_mode ? sclk : (tx_line ^ data_polarity_select);
      transmit_or_clock_pin.oe_n  <= !(port_enable &&
                                       (sync_mode ? clock_source_select : transmit_enable)); // RQ17
    end
  end

  // ==========================================================
  // register read, data one cycle after strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          serial_pkg::REG_TX_CTL: begin
            reg_rdata[serial_pkg::TX_CLK_SRC_BIT] <= clock_source_select;
            reg_rdata[serial_pkg::TX_EN_BIT]      <= transmit_enable;
            reg_rdata[serial_pkg::TX_SYNC_BIT]    <= sync_mode;
            reg_rdata[serial_pkg::TX_BREAK_BIT]   <= send_break_control;
            reg_rdata[serial_pkg::TX_EMPTY_BIT]   <= shift_register_empty;
          end
          serial_pkg::REG_RX_CTL: begin
            reg_rdata[serial_pkg::RX_PORT_EN_BIT] <= port_enable;
            reg_rdata[serial_pkg::RX_SINGLE_BIT]  <= single_receive_enable;
            reg_rdata[serial_pkg::RX_CONT_BIT]    <= continuous_receive_enable;
            reg_rdata[serial_pkg::RX_FRAMING_ERROR_FLAG_BIT]    <= framing_error_flag;
          end
          serial_pkg::REG_RATE_CTL: begin
            reg_rdata[serial_pkg::RT_IDLE_BIT] <= receiver_idle_status; // RQ6
            reg_rdata[serial_pkg::RT_DPOL_BIT] <= data_polarity_select;
            reg_rdata[serial_pkg::RT_CPOL_BIT] <= clock_polarity_select;
            reg_rdata[serial_pkg::RT_WAKE_BIT] <= wake_on_activity_enable;
          end
          serial_pkg::REG_RX_DATA: reg_rdata <= rx_data;
          serial_pkg::REG_BAUD_LO: reg_rdata <= baud_div[7:0];
          serial_pkg::REG_BAUD_HI: reg_rdata <= baud_div[15:8];
          serial_pkg::REG_FLAGS: begin
            reg_rdata[serial_pkg::FL_RX_BIT]     <= receive_interrupt_flag;
            reg_rdata[serial_pkg::FL_TX_BIT]     <= transmit_buffer_empty_flag;
            reg_rdata[serial_pkg::FL_CLKPIN_BIT] <= ck_sync;
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_WAKE_HOLDS_RX: assert property ( // RQ1
    wake_on_activity_enable |=> rx_state == serial_pkg::RX_IDLE)
    else $error("receiver ran while wake enabled");
  AST_WAKE_SETS_FLAG: assert property ( // RQ4
    wake_on_activity_enable && rx_fall |=> receive_interrupt_flag)
    else $error("wake edge did not set receive flag");
  AST_WAKE_CLEARS: assert property ( // RQ4
    wake_on_activity_enable && rx_rise && !reg_wr |=> !wake_on_activity_enable)
    else $error("wake enable not cleared by rising edge");
  AST_READ_CLEARS: assert property ( // RQ5
    reg_rd && reg_addr == serial_pkg::REG_RX_DATA && ce && !a_done && !s_done && !rx_fall
    |=> !receive_interrupt_flag)
    else $error("receive data read left flag set");
  AST_BREAK_ZERO: assert property ( // RQ7
    tx_state == serial_pkg::TX_DATA && tx_brk |-> !tx_line)
    else $error("break data bit not zero");
  AST_BREAK_CLEARS: assert property ( // RQ9
    brk_done && !reg_wr |=> !send_break_control)
    else $error("send break not cleared after break stop");
  AST_SHIFT_EMPTY: assert property ( // RQ10
    ce && tx_state != serial_pkg::TX_IDLE |=> !shift_register_empty)
    else $error("shift empty while transmitting");
  AST_BREAK_FRAMING_ERROR_FLAG: assert property ( // RQ13
    a_done && !rx_lvl |=> framing_error_flag && receive_interrupt_flag)
    else $error("low stop bit did not raise framing error");
  AST_SYNC_IDLE_CLK: assert property ( // RQ19
    ce && !reg_wr && sync_host && s_state == serial_pkg::S_IDLE ##1 ce
    |=> transmit_or_clock_pin.level == $past(clock_polarity_select, 2))
    else $error("idle clock level wrong");
  AST_HOLD_WAITS: assert property ( // RQ20
    !transmit_buffer_empty_flag && tx_state != serial_pkg::TX_IDLE && !load
    |=> !transmit_buffer_empty_flag)
    else $error("holding drained while shifter busy");

  COV_BREAK: cover property (brk_done);
  COV_WAKE: cover property (wake_on_activity_enable && rx_fall);
  COV_SYNC_TX: cover property (s_done && !s_rx);
  COV_SYNC_RX: cover property (s_done && s_rx);

endmodule : serial_break_wake_and_sync_host

`default_nettype wire

// ===== design/serial_pkg.sv
/*
  Shared constants and types for the break, wake-up and synchronous
  host serial block. Assumes an 8-bit register port with word indices.
*/
package serial_pkg;

  // ==========================================================
  // register indices
  localparam logic [3:0] REG_TX_CTL   = 4'h0;
  localparam logic [3:0] REG_RX_CTL   = 4'h1;
  localparam logic [3:0] REG_RATE_CTL = 4'h2;
  localparam logic [3:0] REG_TX_DATA  = 4'h3;
  localparam logic [3:0] REG_RX_DATA  = 4'h4;
  localparam logic [3:0] REG_BAUD_LO  = 4'h5;
  localparam logic [3:0] REG_BAUD_HI  = 4'h6;
  localparam logic [3:0] REG_FLAGS    = 4'h7;

  // ==========================================================
  // field positions
  localparam int TX_CLK_SRC_BIT = 7;
  localparam int TX_EN_BIT      = 5;
  localparam int TX_SYNC_BIT    = 4;
  localparam int TX_BREAK_BIT   = 3;
  localparam int TX_EMPTY_BIT   = 1;
  localparam int RX_PORT_EN_BIT = 7;
  localparam int RX_SINGLE_BIT  = 5;
  localparam int RX_CONT_BIT    = 4;
  localparam int RX_FRAMING_ERROR_FLAG_BIT    = 2;
  localparam int RT_IDLE_BIT    = 6;
  localparam int RT_DPOL_BIT    = 5;
  localparam int RT_CPOL_BIT    = 4;
  localparam int RT_WAKE_BIT    = 1;
  localparam int FL_RX_BIT      = 5;
  localparam int FL_TX_BIT      = 4;
  localparam int FL_CLKPIN_BIT  = 0;

  // ==========================================================
  // reset values and counts
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0019;
  localparam logic [3:0]  DATA_LAST      = 4'h7;
  localparam logic [3:0]  BREAK_LAST     = 4'hB;

  // ==========================================================
  // states and pin carrier
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic {S_IDLE, S_RUN} sync_state_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_t;

endpackage : serial_pkg

// ===== testbench/serial_remote_node.sv
/* remote node: pulls the data wire up, holds it low on request,
   samples synchronous data on trailing clock edges.
   assumes the design's pin carrier type */
`timescale 1ns/100ps
`default_nettype none
module serial_remote_node (
  // clock and controls
  input  wire logic                   clk_sys,
  input  wire logic                   clk_pol,
  input  wire logic                   line_low,
  input  wire logic                   clr,
  // wires
  input  wire serial_pkg::pin_drive_t data_pin,
  input  wire serial_pkg::pin_drive_t clk_pin,
  output var  logic                   data_in,
  output var  logic                   clk_in,
  output var  logic [7:0]             rx_byte,
  output var  logic [3:0]             edges
);
  logic prev;
  // released wires float to the pull-up level
  assign data_in = !data_pin.oe_n ? data_pin.level : !line_low;
  assign clk_in  = clk_pin.oe_n ? 1'b1 : clk_pin.level;
  // trailing edge returns to idle level: sample LSB first
  always_ff @(posedge clk_sys) begin
    prev <= clk_in;
    if (clr) begin
      edges   <= 4'h0;
      rx_byte <= 8'h00;
    end else if (prev != clk_in && clk_in == clk_pol) begin
      edges   <= edges + 4'h1;
      rx_byte <= {data_in, rx_byte[7:1]};
    end
  end
endmodule : serial_remote_node
`default_nettype wire

// ===== testbench/tb.sv
/* bench: break, wake and sync host tests over the register port.
   assumes the design package and the remote node model */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys, srst, reg_wr, reg_rd, clk_pol, line_low, clr, data_in, clk_in, flag_rx, flag_tx;
  logic [3:0] reg_addr, edges;
  logic [7:0] reg_wdata, reg_rdata, rx_byte, v;
  serial_pkg::pin_drive_t dpin, cpin;
  int bad_count, samples_checked, n;
  serial_break_wake_and_sync_host i_serial_break_wake_and_sync_host (.clk_sys(clk_sys), .srst(srst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .receive_or_data_pin_in(data_in), .receive_or_data_pin(dpin), .transmit_or_clock_pin_in(clk_in),
    .transmit_or_clock_pin(cpin), .receive_interrupt_flag(flag_rx), .transmit_buffer_empty_flag(flag_tx));
  serial_remote_node i_serial_remote_node (.clk_sys(clk_sys), .clk_pol(clk_pol), .line_low(line_low), .clr(clr),
    .data_pin(dpin), .clk_pin(cpin), .data_in(data_in), .clk_in(clk_in), .rx_byte(rx_byte), .edges(edges));
  // ==========================================================
  // tasks
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // bounded wait for the next low run on the line, then its length
  task low_run;
    n = 0;
    while (cpin.level !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    while (cpin.level === 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : low_run
  task finish_test;
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // clock and watchdog, run is well under 2000 cycles
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    finish_test;
  end
  // main sequence, async bit time 4 cycles, sync bit time 8 cycles
  initial begin
    {srst, reg_wr, reg_rd, clk_pol, line_low, clr, reg_addr, reg_wdata} = {1'b1, 17'h0};
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    check({7'h0, flag_tx}, 8'h01);
    rd(serial_pkg::REG_BAUD_LO);
    check(v, serial_pkg::BAUD_DIV_RESET[7:0]);
    wr(serial_pkg::REG_BAUD_LO, 8'h03);
    wr(serial_pkg::REG_RX_CTL, 8'h80);
    wr(serial_pkg::REG_TX_CTL, 8'h28);
    wr(serial_pkg::REG_TX_DATA, 8'hFF);
    wr(serial_pkg::REG_TX_DATA, 8'h55);
    low_run;
    check(n[7:0], 8'h34);
    check({7'h0, flag_tx}, 8'h00);
    low_run;
    check(n[7:0], 8'h04);
    check({7'h0, flag_tx}, 8'h01);
    rd(serial_pkg::REG_TX_CTL);
    check(v & 8'h0A, 8'h00);
    repeat (40) @(posedge clk_sys);
    rd(serial_pkg::REG_TX_CTL);
    check(v & 8'h0A, 8'h02);
    $display("test break_tx done");
    wr(serial_pkg::REG_RX_CTL, 8'h90);
    line_low <= 1'b1;
    repeat (52) @(posedge clk_sys);
    line_low <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check({7'h0, flag_rx}, 8'h01);
    rd(serial_pkg::REG_RX_CTL);
    check(v & 8'h04, 8'h04);
    rd(serial_pkg::REG_RX_DATA);
    check(v, 8'h00);
    check({7'h0, flag_rx}, 8'h00);
    $display("test break_rx done");
    // software confirms the receiver is idle before arming wake
    rd(serial_pkg::REG_RATE_CTL);
    check(v & 8'h60, 8'h40);
    wr(serial_pkg::REG_RATE_CTL, 8'h02);
    line_low <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check({7'h0, flag_rx}, 8'h01);
    rd(serial_pkg::REG_RATE_CTL);
    check(v & 8'h02, 8'h02);
    repeat (28) @(posedge clk_sys);
    line_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(serial_pkg::REG_RATE_CTL);
    check(v & 8'h02, 8'h00);
    rd(serial_pkg::REG_RX_DATA);
    check({7'h0, flag_rx}, 8'h00);
    // byte after the wake: nine low bit times, then a high stop
    line_low <= 1'b1;
    repeat (36) @(posedge clk_sys);
    line_low <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check({7'h0, flag_rx}, 8'h01);
    rd(serial_pkg::REG_RX_CTL);
    check(v & 8'h04, 8'h00);
    $display("test wake done");
    wr(serial_pkg::REG_RX_CTL, 8'h80);
    // both polarity pairs: clock idle level and data inversion
    for (int k = 0; k < 2; k++) begin
      wr(serial_pkg::REG_RATE_CTL, k[0] ? 8'h30 : 8'h00);
      clk_pol <= k[0];
      wr(serial_pkg::REG_TX_CTL, 8'hB0);
      clr <= 1'b1;
      wr(serial_pkg::REG_TX_DATA, 8'hA5);
      clr <= 1'b0;
      repeat (120) @(posedge clk_sys);
      check({4'h0, edges}, 8'h08);
      check(rx_byte, k[0] ? 8'h5A : 8'hA5);
      check({cpin.oe_n, cpin.level}, {1'b0, k[0]});
    end
    $display("test sync_host done");
    finish_test;
  end
endmodule : tb
`default_nettype wire
